//--- bench/rtc_ctl_top_tb.sv
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_ctl_top_tb;
  import rtc_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        frc_tick_i = 1'b0;
  logic        gate       = 1'b0;
  rtc_addr_t   addr       = 20'h00000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  rtc_byte_t   wdata      = 8'h00;
  logic        match      = 1'b0;
  logic        hwrap      = 1'b0;
  logic        dwrap      = 1'b0;
  rtc_byte_t   rdata;
  logic        one_hz;
  logic        irq;
  logic        fmt;
  logic        hold;
  logic        carry;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          tick_mode   = 2;
  int          irq_cnt     = 0;
  int          carry_cnt   = 0;
  int          hz_rise     = 0;
  logic        hz_prev     = 1'b0;
  logic [31:0] seed        = 32'h3A0C76E0;
  rtc_addr_t   regs[4]     = '{`RTC_ADDR_SEC, `RTC_ADDR_MIN, `RTC_ADDR_CTLA, `RTC_ADDR_CTLB};

  rtc_ctl_top i_dut (
    .core_clk_i              (core_clk_i),
    .sys_rst_i               (sys_rst_i),
    .frc_tick_i              (frc_tick_i),
    .peripheral_clock_gate_i (gate),
    .bus_addr_i              (addr),
    .bus_wr_i                (wr),
    .bus_rd_i                (rd),
    .bus_wdata_i             (wdata),
    .bus_rdata_o             (rdata),
    .alarm_match_i           (match),
    .hour_wrap_i             (hwrap),
    .day_wrap_i              (dwrap),
    .one_hz_pin_o            (one_hz),
    .rtc_interrupt_o         (irq),
    .hour_format_o           (fmt),
    .calendar_hold_o         (hold),
    .min_carry_o             (carry)
  );

  // 50 MHz core clock
  always #10 core_clk_i = ~core_clk_i;

  // event counters and frc tick; fast mode squeezes one second into 32768 cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    hz_prev <= one_hz;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (carry === 1'b1) carry_cnt <= carry_cnt + 1;
    if (one_hz === 1'b1 && hz_prev === 1'b0) hz_rise <= hz_rise + 1;
    #2;
    frc_tick_i = (tick_mode == 1) || (tick_mode == 2 && cycles % 4 == 0);
  end

  // hang guard, well above the single long count
  always @(posedge core_clk_i) begin
    if (cycles == 45000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // next value of a 00..59 bcd count
  function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
    if (v == 8'h59) return 8'h00;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  // strobe held one cycle, released after the sampling edge
  task automatic bus_wr(input rtc_addr_t a, input rtc_byte_t d);
    @(posedge core_clk_i);
    #2;
    addr = a;
    wdata = d;
    wr = 1'b1;
    idle(1);
    wr = 1'b0;
  endtask

  task automatic bus_rd(input rtc_addr_t a, output rtc_byte_t d);
    @(posedge core_clk_i);
    #2;
    addr = a;
    rd = 1'b1;
    idle(1);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic check_byte(input rtc_byte_t got, input rtc_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_check(input rtc_addr_t a, input rtc_byte_t exp);
    rtc_byte_t d;
    bus_rd(a, d);
    check_byte(d, exp);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rtc_byte_t   v;
    logic [31:0] r;
    int          t0;
    int          irq0;
    int          i;
    repeat (6) @(posedge core_clk_i);
    #2;
    sys_rst_i = 1'b0;
    // gate off: writes dropped, reads return reset values
    bus_wr(`RTC_ADDR_CTLA, 8'h08);
    rd_check(`RTC_ADDR_CTLA, 8'h00);
    gate = 1'b1;
    for (i = 0; i < 4; i++) begin
      rd_check(regs[i], `RTC_RST_BYTE);
    end
    r = rnd();
    rd_check({4'h1, r[15:0]}, 8'h00);
    // random control values while stopped, format changed under hold
    bus_wr(`RTC_ADDR_CTLB, 8'h01);
    for (i = 0; i < 3; i++) begin
      r = rnd();
      v = r[7:0] & 8'h2F;
      bus_wr(`RTC_ADDR_CTLA, v);
      rd_check(`RTC_ADDR_CTLA, v);
      check_bit(fmt, v[3]);
      idle(40);
      check_bit(one_hz, 1'b0);
    end
    bus_wr(`RTC_ADDR_CTLB, 8'h00);
    // 59:59 rolls over after one full prescaler period
    bus_wr(`RTC_ADDR_SEC, 8'h59);
    bus_wr(`RTC_ADDR_MIN, 8'h59);
    idle(12);
    rd_check(`RTC_ADDR_SEC, 8'h59);
    rd_check(`RTC_ADDR_MIN, 8'h59);
    irq0 = irq_cnt;
    tick_mode = 1;
    // keep the format bit left by the random loop, it may only change under hold
    bus_wr(`RTC_ADDR_CTLA, 8'hA3 | (v & 8'h08));
    t0 = cycles;
    for (i = 0; i < 40000 && carry_cnt == 0; i++) begin
      @(posedge core_clk_i);
    end
    t0 = cycles - t0;
    idle(3);
    check_bit(t0 >= 32764 && t0 <= 32776, 1'b1);
    check_bit(carry_cnt == 1, 1'b1);
    check_bit(irq_cnt - irq0 == 1, 1'b1);
    check_bit(hz_rise == 1, 1'b1);
    // hold, with flag ones written so the period flag survives
    tick_mode = 2;
    bus_wr(`RTC_ADDR_CTLB, 8'h19);
    idle(6);
    rd_check(`RTC_ADDR_CTLB, 8'h0B);
    check_bit(hold, 1'b1);
    rd_check(`RTC_ADDR_SEC, bcd_inc(8'h59));
    rd_check(`RTC_ADDR_MIN, bcd_inc(8'h59));
    bus_wr(`RTC_ADDR_SEC, 8'h42);
    bus_wr(`RTC_ADDR_CTLA, 8'hAB);
    idle(2);
    check_bit(fmt, 1'b1);
    bus_wr(`RTC_ADDR_CTLB, 8'h18);
    idle(6);
    check_bit(hold, 1'b0);
    rd_check(`RTC_ADDR_SEC, 8'h42);
    bus_wr(`RTC_ADDR_CTLB, 8'h10);
    rd_check(`RTC_ADDR_CTLB, 8'h00);
    bus_wr(`RTC_ADDR_CTLA, 8'h2B);
    idle(3);
    check_bit(one_hz, 1'b0);
    // alarm with interrupt, without interrupt, then compare disabled
    // alarm set up while stopped, compare enable last; format stays 24 h
    bus_wr(`RTC_ADDR_CTLB, 8'h40);
    bus_wr(`RTC_ADDR_CTLB, 8'hC0);
    bus_wr(`RTC_ADDR_CTLA, 8'h88);
    irq0 = irq_cnt;
    match = 1'b1;
    idle(30);
    rd_check(`RTC_ADDR_CTLB, 8'hD0);
    check_bit(irq_cnt - irq0 == 1, 1'b1);
    match = 1'b0;
    bus_wr(`RTC_ADDR_CTLB, 8'h00);
    bus_wr(`RTC_ADDR_CTLB, 8'h80);
    idle(8);
    irq0 = irq_cnt;
    match = 1'b1;
    idle(30);
    rd_check(`RTC_ADDR_CTLB, 8'h90);
    check_bit(irq_cnt == irq0, 1'b1);
    match = 1'b0;
    bus_wr(`RTC_ADDR_CTLB, 8'h00);
    idle(8);
    match = 1'b1;
    idle(30);
    rd_check(`RTC_ADDR_CTLB, 8'h00);
    // day and month sources from the higher counters, period changed only while stopped
    bus_wr(`RTC_ADDR_CTLA, 8'h08);
    for (i = 0; i < 2; i++) begin
      bus_wr(`RTC_ADDR_CTLA, i ? 8'h0F : 8'h0D);
      irq0 = irq_cnt;
      hwrap = (i == 1);
      dwrap = (i == 0);
      idle(1);
      hwrap = 1'b0;
      dwrap = 1'b0;
      idle(3);
      check_bit(irq_cnt == irq0, 1'b1);
      hwrap = (i == 0);
      dwrap = (i == 1);
      idle(1);
      hwrap = 1'b0;
      dwrap = 1'b0;
      idle(3);
      check_bit(irq_cnt - irq0 == 1, 1'b1);
      rd_check(`RTC_ADDR_CTLB, 8'h08);
      bus_wr(`RTC_ADDR_CTLB, 8'h10);
    end
    complete_run();
  end
endmodule

//--- hdl/rtc_bcd60.sv
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_bcd60 (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clear_i,
  rtc_cnt_if.cnt    cnt_io
);
  import rtc_pkg::*;

  rtc_byte_t value_q;

  // a load beats an increment arriving on the same edge
  assign cnt_io.carry = cnt_io.inc & ~cnt_io.load & (value_q == `RTC_BCD_MAX); // RULE25 RULE22
  assign cnt_io.value = value_q;

  // counter state, values outside 00..59 are only what software put there
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      value_q <= `RTC_RST_BYTE;
    end else if (clear_i) begin
      value_q <= `RTC_RST_BYTE;
    end else if (cnt_io.load) begin
      value_q <= cnt_io.load_val; // RULE22 RULE21
    end else if (cnt_io.inc) begin
      value_q <= rtc_bcd_next(value_q); // RULE20 RULE25
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  bcd_load_wins_a: assert property (cnt_io.load && !clear_i |=>
      value_q == $past(cnt_io.load_val)) // RULE22
    else $error("written value did not reach counter");
  bcd_wrap_a: assert property (cnt_io.carry && !clear_i |=> value_q == `RTC_BCD_ZERO) // RULE25
    else $error("counter did not wrap to 00 on carry");
endmodule

//--- hdl/rtc_cnt_if.sv
`timescale 1ns/100ps
interface rtc_cnt_if;
  logic              inc;
  logic              load;
  logic              carry;
  rtc_pkg::rtc_byte_t load_val;
  rtc_pkg::rtc_byte_t value;

  modport ctl (output inc, output load, output load_val, input value, input carry);
  modport cnt (input inc, input load, input load_val, output value, output carry);
endinterface

//--- hdl/rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// Notes on behaviour
// RULE1 - counters advance only while counter_run is set
// RULE2 - 1 Hz pin needs enable and counter_run
// RULE3 - software leaves 1 Hz enable alone while running
// RULE4 - format bit picks 12 or 24 hour
// RULE5 - software changes format only under hold_request
// RULE6 - period_select picks the periodic event source
// RULE7 - software masks interrupt before changing period
// RULE8 - alarm compare only with alarm_match_enable set
// RULE9 - software masks interrupt before changing alarm enable
// RULE10 - alarm_irq_enable gates alarm onto rtc_interrupt
// RULE11 - alarm_flag sets one frc tick after match
// RULE12 - flags set by events, cleared by writing zero
// RULE13 - hold freezes calendar, prescaler keeps running
// RULE14 - hold_ack follows hold_request within one tick
// RULE15 - overflow during hold applied later unless seconds written
// RULE16 - software ends hold within one second
// RULE17 - software waits for hold_ack before access
// RULE18 - software writes control_b whole, ones in flags
// RULE19 - periodic and alarm share one interrupt
// RULE20 - seconds count BCD 00-59 on prescale overflow
// RULE21 - seconds write buffered, clears the prescaler
// RULE22 - minutes BCD, write overrides seconds carry
// RULE23 - gate off ignores writes, reads reset values
// RULE24 - prescaler overflows at 7FFF into seconds
// RULE25 - wrap 59 to 00 with carry same edge

// register addresses on the cpu bus
`define RTC_ADDR_SEC      20'hFFF92
`define RTC_ADDR_MIN      20'hFFF93
`define RTC_ADDR_CTLA     20'hFFF9D
`define RTC_ADDR_CTLB     20'hFFF9E

// reset values
`define RTC_RST_BYTE      8'h00
`define RTC_RST_PERIOD    3'h0

// rtc_control_a fields
`define RTC_A_RUN         7
`define RTC_A_ONE_HZ      5
`define RTC_A_FMT         3
`define RTC_A_PER_HI      2
`define RTC_A_PER_LO      0

// rtc_control_b fields
`define RTC_B_AMEN        7
`define RTC_B_AIE         6
`define RTC_B_AFLAG       4
`define RTC_B_PFLAG       3
`define RTC_B_ACK         1
`define RTC_B_REQ         0

// prescaler and counter limits
`define RTC_PRESCALE_TOP  16'h7FFF
`define RTC_PRESCALE_HALF 16'h3FFF
`define RTC_ONE_HZ_BIT    14
`define RTC_BCD_MAX       8'h59
`define RTC_BCD_ZERO      8'h00
`endif

//--- hdl/rtc_ctl_top.sv
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_ctl_top (
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          frc_tick_i,
  input  wire logic          peripheral_clock_gate_i,
  input  rtc_pkg::rtc_addr_t bus_addr_i,
  input  wire logic          bus_wr_i,
  input  wire logic          bus_rd_i,
  input  rtc_pkg::rtc_byte_t bus_wdata_i,
  output rtc_pkg::rtc_byte_t bus_rdata_o,
  input  wire logic          alarm_match_i,
  input  wire logic          hour_wrap_i,
  input  wire logic          day_wrap_i,
  output logic               one_hz_pin_o,
  output logic               rtc_interrupt_o,
  output logic               hour_format_o,
  output logic               calendar_hold_o,
  output logic               min_carry_o
);
  import rtc_pkg::*;

  rtc_cnt_if sec_if ();
  rtc_cnt_if min_if ();

  // control_a state
  logic        counter_run_q;
  logic        one_hz_out_enable_q;
  logic        hour_format_select_q;
  rtc_period_e period_select_q;
  // control_b state
  logic        alarm_match_enable_q;
  logic        alarm_irq_enable_q;
  logic        alarm_flag_q;
  logic        period_flag_q;
  logic        hold_ack_q;
  logic        hold_request_q;
  // buffered count writes and deferred overflow
  logic        sec_pend_q;
  rtc_byte_t   sec_buf_q;
  logic        min_pend_q;
  rtc_byte_t   min_buf_q;
  logic        ovf_pend_q;
  // alarm detection and outputs
  logic        match_last_q;
  logic        alarm_seen_q;
  logic        irq_q;
  logic        one_hz_q;
  rtc_byte_t   rdata_q;

  logic        gate_off;
  logic        wr_a;
  logic        wr_b;
  logic        wr_s;
  logic        wr_m;
  logic        freeze;
  logic        pre_ovf;
  logic        pre_half;
  logic        sec_inc;
  logic        period_hit;
  logic        alarm_set;
  rtc_pre_t    pre_count;

  // write decode; a closed clock gate swallows every write
  assign gate_off = ~peripheral_clock_gate_i;
  assign wr_a     = bus_wr_i & ~gate_off & (bus_addr_i == `RTC_ADDR_CTLA); // RULE23
  assign wr_b     = bus_wr_i & ~gate_off & (bus_addr_i == `RTC_ADDR_CTLB); // RULE23
  assign wr_s     = bus_wr_i & ~gate_off & (bus_addr_i == `RTC_ADDR_SEC); // RULE23
  assign wr_m     = bus_wr_i & ~gate_off & (bus_addr_i == `RTC_ADDR_MIN); // RULE23

  // calendar stays frozen from the request until the ack drops again
  assign freeze = hold_request_q | hold_ack_q; // RULE13

  // control_a: run, 1 Hz enable, hour format, period select
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      counter_run_q        <= 1'b0;
      one_hz_out_enable_q  <= 1'b0;
      hour_format_select_q <= 1'b0;
      period_select_q      <= RTC_PER_NONE;
    end else if (gate_off) begin
      counter_run_q        <= 1'b0; // RULE23
      one_hz_out_enable_q  <= 1'b0;
      hour_format_select_q <= 1'b0;
      period_select_q      <= RTC_PER_NONE;
    end else if (wr_a) begin
      counter_run_q        <= bus_wdata_i[`RTC_A_RUN]; // RULE1
      one_hz_out_enable_q  <= bus_wdata_i[`RTC_A_ONE_HZ];
      hour_format_select_q <= bus_wdata_i[`RTC_A_FMT]; // RULE4
      period_select_q      <= rtc_period_e'(bus_wdata_i[`RTC_A_PER_HI:`RTC_A_PER_LO]); // RULE6
    end
  end

  // control_b plain bits
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_match_enable_q <= 1'b0;
      alarm_irq_enable_q   <= 1'b0;
      hold_request_q       <= 1'b0;
    end else if (gate_off) begin
      alarm_match_enable_q <= 1'b0;
      alarm_irq_enable_q   <= 1'b0;
      hold_request_q       <= 1'b0;
    end else if (wr_b) begin
      alarm_match_enable_q <= bus_wdata_i[`RTC_B_AMEN]; // RULE8
      alarm_irq_enable_q   <= bus_wdata_i[`RTC_B_AIE]; // RULE10
      hold_request_q       <= bus_wdata_i[`RTC_B_REQ]; // RULE13
    end
  end

  // ack samples the request on the next frc tick, so it lags by at most one tick
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_ack_q <= 1'b0;
    end else if (gate_off) begin
      hold_ack_q <= 1'b0;
    end else if (frc_tick_i) begin
      hold_ack_q <= hold_request_q; // RULE14
    end
  end

  // seconds write buffer, applied on the next frc tick; a new write wins over the apply
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_pend_q <= 1'b0;
      sec_buf_q  <= `RTC_RST_BYTE;
    end else if (gate_off) begin
      sec_pend_q <= 1'b0;
      sec_buf_q  <= `RTC_RST_BYTE;
    end else if (wr_s) begin
      sec_pend_q <= 1'b1; // RULE21
      sec_buf_q  <= bus_wdata_i;
    end else if (frc_tick_i) begin
      sec_pend_q <= 1'b0;
    end
  end

  // minutes write buffer, same timing as seconds
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      min_pend_q <= 1'b0;
      min_buf_q  <= `RTC_RST_BYTE;
    end else if (gate_off) begin
      min_pend_q <= 1'b0;
      min_buf_q  <= `RTC_RST_BYTE;
    end else if (wr_m) begin
      min_pend_q <= 1'b1; // RULE22
      min_buf_q  <= bus_wdata_i;
    end else if (frc_tick_i) begin
      min_pend_q <= 1'b0;
    end
  end

  // overflow seen during hold is kept; a seconds write throws it away
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_pend_q <= 1'b0;
    end else if (gate_off | wr_s | sec_if.load) begin
      ovf_pend_q <= 1'b0; // RULE15
    end else if (pre_ovf & freeze) begin
      ovf_pend_q <= 1'b1; // RULE15
    end else if (sec_inc) begin
      ovf_pend_q <= 1'b0;
    end
  end

  // a deferred overflow is replayed on the first tick after the hold
  assign sec_inc = counter_run_q & ~freeze & (pre_ovf | (frc_tick_i & ovf_pend_q)); // RULE15 RULE20

  assign sec_if.inc      = sec_inc; // RULE20
  assign sec_if.load     = frc_tick_i & sec_pend_q; // RULE21
  assign sec_if.load_val = sec_buf_q;
  assign min_if.inc      = sec_if.carry; // RULE22 RULE25
  assign min_if.load     = frc_tick_i & min_pend_q; // RULE22
  assign min_if.load_val = min_buf_q;

  rtc_prescale u_prescale (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_i     (frc_tick_i),
    .run_i      (counter_run_q),
    .clear_i    (gate_off | sec_if.load),
    .count_o    (pre_count),
    .ovf_o      (pre_ovf),
    .half_o     (pre_half)
  );

  rtc_bcd60 u_sec (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clear_i    (gate_off),
    .cnt_io     (sec_if.cnt)
  );

  rtc_bcd60 u_min (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clear_i    (gate_off),
    .cnt_io     (min_if.cnt)
  );

  // periodic event source; higher calendar wraps come from the hour and day counters
  always_comb begin
    case (period_select_q)
      RTC_PER_NONE: period_hit = 1'b0; // RULE6
      RTC_PER_HALF: period_hit = pre_half | sec_inc;
      RTC_PER_SEC:  period_hit = sec_inc;
      RTC_PER_MIN:  period_hit = sec_if.carry;
      RTC_PER_HOUR: period_hit = min_if.carry;
      RTC_PER_DAY:  period_hit = hour_wrap_i;
      default:      period_hit = day_wrap_i;
    endcase
  end

  // alarm match edge caught on a tick, flag lands on the following tick
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      match_last_q <= 1'b0;
      alarm_seen_q <= 1'b0;
    end else if (gate_off) begin
      match_last_q <= 1'b0;
      alarm_seen_q <= 1'b0;
    end else if (frc_tick_i) begin
      match_last_q <= alarm_match_i;
      alarm_seen_q <= alarm_match_enable_q & alarm_match_i & ~match_last_q; // RULE8 RULE11
    end
  end

  assign alarm_set = frc_tick_i & alarm_seen_q; // RULE11

  // status flags: an event in the clearing cycle wins, writing one keeps the flag
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_flag_q  <= 1'b0;
      period_flag_q <= 1'b0;
    end else if (gate_off) begin
      alarm_flag_q  <= 1'b0;
      period_flag_q <= 1'b0;
    end else begin
      if (alarm_set) begin
        alarm_flag_q <= 1'b1; // RULE11
      end else if (wr_b & ~bus_wdata_i[`RTC_B_AFLAG]) begin
        alarm_flag_q <= 1'b0; // RULE12
      end
      if (period_hit) begin
        period_flag_q <= 1'b1; // RULE12
      end else if (wr_b & ~bus_wdata_i[`RTC_B_PFLAG]) begin
        period_flag_q <= 1'b0; // RULE12
      end
    end
  end

  // one shared interrupt pulse; software tells the cause from the two flags
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ~gate_off & (period_hit | (alarm_set & alarm_irq_enable_q)); // RULE19 RULE10
    end
  end

  // 1 Hz square wave from the prescaler's upper bit
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      one_hz_q <= 1'b0;
    end else begin
      one_hz_q <= one_hz_out_enable_q & counter_run_q & pre_count[`RTC_ONE_HZ_BIT]; // RULE2
    end
  end

  // registered read data; gate off returns reset values
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= `RTC_RST_BYTE;
    end else if (bus_rd_i) begin
      if (gate_off) begin
        rdata_q <= `RTC_RST_BYTE; // RULE23
      end else begin
        case (bus_addr_i)
          `RTC_ADDR_SEC:  rdata_q <= sec_if.value;
          `RTC_ADDR_MIN:  rdata_q <= min_if.value;
          `RTC_ADDR_CTLA: rdata_q <= {counter_run_q, 1'b0, one_hz_out_enable_q, 1'b0,
                                      hour_format_select_q, period_select_q};
          `RTC_ADDR_CTLB: rdata_q <= {alarm_match_enable_q, alarm_irq_enable_q, 1'b0,
                                      alarm_flag_q, period_flag_q, 1'b0, hold_ack_q,
                                      hold_request_q}; // RULE19
          default:        rdata_q <= `RTC_RST_BYTE;
        endcase
      end
    end
  end

  // the hour counter converts its value when this level changes
  assign hour_format_o   = hour_format_select_q; // RULE4
  assign calendar_hold_o = freeze; // RULE13
  assign min_carry_o     = min_if.carry; // RULE25
  assign rtc_interrupt_o = irq_q;
  assign one_hz_pin_o    = one_hz_q;
  assign bus_rdata_o     = rdata_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence alarm_edge_s;
    frc_tick_i && peripheral_clock_gate_i && alarm_match_enable_q && alarm_match_i
      && !match_last_q;
  endsequence
  sequence next_tick_s;
    frc_tick_i && peripheral_clock_gate_i;
  endsequence

  one_hz_off_a: assert property (!(one_hz_out_enable_q && counter_run_q) |=> !one_hz_pin_o) // RULE2
    else $error("1 Hz output active while disabled or stopped");
  // the tick after the match may be several core cycles away, so take the first one
  alarm_flag_delay_a: assert property (first_match(alarm_edge_s ##[1:8] next_tick_s) |=>
      alarm_flag_q) // RULE11
    else $error("alarm flag not set one tick after match");
  flag_keep_a: assert property (wr_b && bus_wdata_i[`RTC_B_PFLAG] && period_flag_q |=>
      period_flag_q) // RULE12
    else $error("writing one cleared the period flag");
  hold_ack_a: assert property (frc_tick_i && hold_request_q && !gate_off |=> hold_ack_q) // RULE14
    else $error("hold ack missing one tick after request");
  hold_freeze_a: assert property (hold_ack_q |-> !sec_if.inc) // RULE13
    else $error("seconds advanced during hold");
  sec_clear_pre_a: assert property (sec_if.load |=> pre_count == 16'h0000) // RULE21
    else $error("prescaler not cleared by seconds write");
  alarm_irq_gate_a: assert property (alarm_set && !alarm_irq_enable_q && !period_hit |=>
      !rtc_interrupt_o) // RULE10
    else $error("alarm raised interrupt while disabled");
  gate_reset_a: assert property (gate_off |=> !counter_run_q && !hold_request_q
      && period_select_q == RTC_PER_NONE) // RULE23
    else $error("registers not held at reset while gate off");
  ovf_replay_a: assert property (pre_ovf && freeze && counter_run_q && !wr_s ##1
      (!freeze && frc_tick_i && !sec_if.load && ovf_pend_q) |-> sec_if.inc) // RULE15
    else $error("overflow held during hold was not replayed");
endmodule

//--- hdl/rtc_pkg.sv
package rtc_pkg;
  typedef logic [7:0]  rtc_byte_t;
  typedef logic [15:0] rtc_pre_t;
  typedef logic [19:0] rtc_addr_t;

  typedef enum logic [2:0] {
    RTC_PER_NONE  = 3'h0,
    RTC_PER_HALF  = 3'h1,
    RTC_PER_SEC   = 3'h2,
    RTC_PER_MIN   = 3'h3,
    RTC_PER_HOUR  = 3'h4,
    RTC_PER_DAY   = 3'h5,
    RTC_PER_MON_A = 3'h6,
    RTC_PER_MON_B = 3'h7
  } rtc_period_e;

  // next bcd value of a 00..59 counter
  function automatic rtc_byte_t rtc_bcd_next(input rtc_byte_t v);
    rtc_byte_t r;
    r = v;
    if (v == 8'h59) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction
endpackage

//--- hdl/rtc_prescale.sv
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_prescale (
  input  wire logic      core_clk_i,
  input  wire logic      sys_rst_i,
  input  wire logic      tick_i,
  input  wire logic      run_i,
  input  wire logic      clear_i,
  output rtc_pkg::rtc_pre_t count_o,
  output logic           ovf_o,
  output logic           half_o
);
  import rtc_pkg::*;

  rtc_pre_t count_q;

  // overflow and half-second marks are strobes on the frc tick
  assign ovf_o   = tick_i & run_i & (count_q == `RTC_PRESCALE_TOP); // RULE24
  assign half_o  = tick_i & run_i & (count_q == `RTC_PRESCALE_HALF);
  assign count_o = count_q;

  // divider advances on each tick while counter_run is set; hold does not stop it
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= 16'h0000;
    end else if (clear_i) begin
      count_q <= 16'h0000; // RULE21
    end else if (tick_i & run_i) begin // RULE1 RULE13
      count_q <= ovf_o ? 16'h0000 : count_q + 16'h0001; // RULE24
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  pre_wrap_a: assert property (ovf_o && !clear_i |=> count_q == 16'h0000) // RULE24
    else $error("prescaler did not wrap after 7FFF");
  pre_stop_a: assert property (!run_i && !clear_i |=> $stable(count_q)) // RULE1
    else $error("prescaler moved while stopped");
endmodule
